/* File: src/asp_parser.sv */
// ASCII command interpreter behind a half-duplex asynchronous serial port.
// Assumes i_rxd is synchronous to i_clk and that the register store
// outside answers a request in the same cycle.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps

// Function
// - One stop bit, then hunt next start
// - Half duplex: ignore input while replying
// - Each character is ten bit periods, eleven with parity
// - Read reply: value, then CR, LF
// - Write first, then reply CR LF
// - Dollar terminator: reply within 50-100 ms
// - Asterisk terminator: reply within 2-50 ms
// - After last reply character accept commands
// - Command starts with S or s
// - Decimal node address, default zero
// - Node zero addresses every device
// - Only R/W operation, else abandon
// - Address decimal 1-65535 or letter A-R
// - Read without address returns display
// - Non-digit separator, not a terminator; after a letter address a digit is also taken as separator
// - Write data signed, seven digits max
// - Terminator dollar or asterisk only last
// - Invalid register: NUL then CR LF
// - Start bit, eight bits LSB first, parity
// - Parity none, odd or even
module asp_parser
	import asp_pkg::*;
#(
	parameter int BAUD_DIV = BAUD_DIV_DEF,
	parameter int DOL_CYC = DOL_MIN_CYC,
	parameter int AST_CYC = AST_MIN_CYC
)(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_rxd,
	input wire logic [1:0] i_parity,
	input wire logic [7:0] i_node_addr,
	input wire logic [31:0] i_reg_rdata,
	input wire logic i_reg_ok,
	output logic o_txd,
	output logic o_tx_en,
	output logic o_reg_req,
	output logic o_reg_we,
	output logic [15:0] o_reg_addr,
	output logic [31:0] o_reg_wdata
);

	// ***************************************************************
	// Elaboration checks
	// ***************************************************************
	if (BAUD_DIV < 4 || BAUD_DIV >= (1 << DIV_W))
		$error("BAUD_DIV out of range");
	if (DOL_CYC < 1 || AST_CYC < 1 || DOL_CYC >= (1 << DLY_W)
		|| AST_CYC >= (1 << DLY_W))
		$error("reply delay out of range");

	localparam logic [DIV_W-1:0] DIV_L = DIV_W'(BAUD_DIV - 1);
	localparam logic [DIV_W-1:0] HALF_L = DIV_W'(BAUD_DIV / 2);
	localparam logic [DLY_W-1:0] DOL_L = DLY_W'(DOL_CYC - 1);
	localparam logic [DLY_W-1:0] AST_L = DLY_W'(AST_CYC - 1);
	// Windows follow the chosen minimum delays and keep their max/min
	// ratio, so shortened delays in simulation stay checkable
	localparam logic [DLY_W:0] DOL_LO = (DLY_W+1)'(DOL_CYC);
	localparam logic [DLY_W:0] DOL_HI =
		(DLY_W+1)'(DOL_CYC * DOL_MAX_MS / DOL_MIN_MS);
	localparam logic [DLY_W:0] AST_LO = (DLY_W+1)'(AST_CYC);
	localparam logic [DLY_W:0] AST_HI =
		(DLY_W+1)'(AST_CYC * AST_MAX_MS / AST_MIN_MS);

	asp_s st;
	asp_s n;
	logic tx_load;
	logic [7:0] tx_ch;

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb
	begin
		logic [7:0] c;
		logic [7:0] up;
		logic [3:0] d;
		logic is_dig;
		logic is_term;
		logic par_en;
		logic [3:0] nb;
		logic [9:0] sh;
		logic [7:0] rb;
		logic rp;
		logic [11:0] nn;
		logic [19:0] na;
		logic send;
		asp_st_e nx;
		logic [31:0] p;
		c = st.rx_byte;
		up = c & CASE_MASK;
		d = c[3:0];
		is_dig = c >= CH_ZERO && c <= CH_NINE;
		is_term = c == CH_DOL || c == CH_AST;
		par_en = i_parity != PAR_NONE;
		nb = par_en ? 4'hA : 4'h9;
		sh = {i_rxd, st.rx_sh[9:1]};
		rb = par_en ? sh[7:0] : sh[8:1];
		rp = ^{rb, sh[8]} ^ (i_parity == PAR_ODD);
		nn = 12'(st.node) * 12'hA + 12'(d);
		na = 20'(st.addr) * 20'hA + 20'(d);
		send = 1'b0;
		nx = st.state;
		tx_ch = CH_NUL;
		tx_load = 1'b0;
		p = pow10(st.pidx);
		n = st;
		n.rx_vld = 1'b0;
		n.reg_req = 1'b0;

		// Receiver runs only while a command may arrive
		if (!st.rx_busy)
		begin
			if (!i_rxd && !st.tx_busy && st.state <= S_DATA)
			begin
				n.rx_busy = 1'b1;
				n.rx_cnt = HALF_L;
				n.rx_n = nb + 4'h1;
			end
		end
		else if (st.rx_cnt != '0)
			n.rx_cnt = st.rx_cnt - 1'b1;
		else if (st.rx_n == nb + 4'h1)
		begin
			// Mid start bit: a high line here was a glitch
			n.rx_busy = !i_rxd;
			n.rx_cnt = DIV_L;
			n.rx_n = nb;
		end
		else
		begin
			n.rx_sh = sh;
			n.rx_cnt = DIV_L;
			n.rx_n = st.rx_n - 1'b1;
			if (st.rx_n == 4'h1)
			begin
				n.rx_busy = 1'b0;
				n.rx_vld = 1'b1;
				n.rx_byte = rb;
				n.rx_err = !sh[9] || (par_en && rp);
			end
		end

		// Transmitter: start, 8 data, optional parity, one stop
		if (st.tx_busy && st.tx_cnt != '0)
			n.tx_cnt = st.tx_cnt - 1'b1;
		else if (st.tx_busy)
		begin
			n.tx_cnt = DIV_L;
			if (st.tx_n == 4'h0)
				n.tx_busy = 1'b0;
			else
			begin
				n.txd = st.tx_sh[0];
				n.tx_sh = {1'b1, st.tx_sh[9:1]};
				n.tx_n = st.tx_n - 1'b1;
			end
		end

		case (st.state)
			S_IDLE:
				if (st.rx_vld && !st.rx_err && up == CH_S)
				begin
					n.state = S_NODE;
					n.node = '0;
					n.addr = '0;
					n.has_addr = 1'b0;
					n.lt = 1'b0;
					n.addr_bad = 1'b0;
					n.neg = 1'b0;
					n.ndig = '0;
					n.data = '0;
				end
			S_NODE:
				if (st.rx_vld)
				begin
					n.state = S_IDLE;
					if (st.rx_err)
						n.state = S_IDLE;
					else if (is_dig && nn <= NODE_MAX)
					begin
						n.node = nn[7:0];
						n.state = S_NODE;
					end
					else if (up == CH_R || up == CH_W)
					begin
						n.wr = up == CH_W;
						n.state = S_ADDR;
					end
				end
			S_ADDR:
				if (st.rx_vld)
				begin
					n.state = S_IDLE;
					if (st.rx_err)
						n.state = S_IDLE;
					else if (is_dig && !st.lt)
					begin
						n.state = S_ADDR;
						n.has_addr = 1'b1;
						if (na > ADDR_MAX)
							n.addr_bad = 1'b1;
						else
							n.addr = na[15:0];
					end
					else if (up >= CH_A && up <= CH_Z && !st.has_addr)
					begin
						n.state = S_ADDR;
						n.has_addr = 1'b1;
						n.lt = 1'b1;
						n.addr = 16'(up - CH_A) + 16'h1;
						n.addr_bad = up > CH_R;
					end
					else if (is_term && !st.wr)
						nx = S_WAIT;
					else if (!is_term && st.wr && st.has_addr)
						n.state = S_DATA;
				end
			S_DATA:
				if (st.rx_vld)
				begin
					n.state = S_IDLE;
					if (st.rx_err)
						n.state = S_IDLE;
					else if (c == CH_MINUS && st.ndig == '0 && !st.neg)
					begin
						n.neg = 1'b1;
						n.state = S_DATA;
					end
					else if (is_dig && st.ndig != DATA_DIGITS)
					begin
						n.data = 32'(st.data * 32'hA) + 32'(d);
						n.ndig = st.ndig + 1'b1;
						n.state = S_DATA;
					end
					else if (is_term && st.ndig != '0)
						nx = S_WAIT;
				end
			S_WAIT:
				if (st.dly == '0)
					n.state = S_ACC;
				else
					n.dly = st.dly - 1'b1;
			S_ACC:
				if (st.addr_bad || (st.has_addr && st.addr == '0))
					n.state = S_NUL;
				else
				begin
					n.reg_req = 1'b1;
					if (!st.wr)
						n.data = '0;
					n.state = S_CAPT;
				end
			S_CAPT:
				if (!i_reg_ok)
					n.state = S_NUL;
				else if (st.wr)
					n.state = S_CR;
				else
				begin
					n.neg = i_reg_rdata[31];
					n.mag = i_reg_rdata[31] ? 32'(-i_reg_rdata) : i_reg_rdata;
					n.pidx = TOP_DIGIT;
					n.dig = '0;
					n.started = 1'b0;
					n.state = S_SIGN;
				end
			S_SIGN:
				if (st.neg)
				begin
					send = 1'b1;
					tx_ch = CH_MINUS;
					nx = S_DIV;
				end
				else
					n.state = S_DIV;
			S_DIV:
				// One subtraction a cycle keeps the divider small
				if (st.mag >= p)
				begin
					n.mag = st.mag - p;
					n.dig = st.dig + 1'b1;
				end
				else
					n.state = S_DIG;
			S_DIG:
				if (st.dig != '0 || st.started || st.pidx == '0)
				begin
					send = 1'b1;
					tx_ch = CH_ZERO + 8'(st.dig);
					nx = st.pidx == '0 ? S_CR : S_DIV;
				end
				else
				begin
					n.pidx = st.pidx - 1'b1;
					n.state = S_DIV;
				end
			S_NUL:
			begin
				send = 1'b1;
				tx_ch = CH_NUL;
				nx = S_CR;
			end
			S_CR:
			begin
				send = 1'b1;
				tx_ch = CH_CR;
				nx = S_LF;
			end
			S_LF:
			begin
				send = 1'b1;
				tx_ch = CH_LF;
				nx = S_DONE;
			end
			S_DONE:
				if (!st.tx_busy)
					n.state = S_IDLE;
			default:
				n.state = S_IDLE;
		endcase

		// Terminator accepted: act on broadcast or own node only
		if (nx == S_WAIT && st.state != S_WAIT)
		begin
			if (st.node == '0 || st.node == i_node_addr)
			begin
				n.state = S_WAIT;
				n.dol = c == CH_DOL;
				n.dly = c == CH_DOL ? DOL_L : AST_L;
				n.first = 1'b1;
			end
			else
				n.state = S_IDLE;
		end

		if (send && !st.tx_busy)
		begin
			tx_load = 1'b1;
			n.tx_busy = 1'b1;
			n.txd = 1'b0;
			n.tx_sh = {1'b1, par_en ? (^tx_ch ^ (i_parity == PAR_ODD))
				: 1'b1, tx_ch};
			n.tx_n = nb;
			n.tx_cnt = DIV_L;
			n.first = 1'b0;
			n.state = nx;
			if (st.state == S_DIG)
			begin
				n.started = 1'b1;
				n.dig = '0;
				n.pidx = st.pidx == '0 ? st.pidx : st.pidx - 1'b1;
			end
		end
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			st <= '0;
			st.state <= S_IDLE;
			st.txd <= 1'b1;
		end
		else
			st <= n;
	end

	assign o_txd = st.txd;
	assign o_tx_en = st.tx_busy;
	assign o_reg_req = st.reg_req;
	assign o_reg_we = st.wr;
	assign o_reg_addr = st.addr;
	assign o_reg_wdata = st.neg ? 32'(-st.data) : st.data;

	// ***************************************************************
	// Checks
	// ***************************************************************
	// Cycles since the terminator was taken, for the reply window
	logic [DLY_W:0] since_term;
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || st.state <= S_DATA)
			since_term <= '0;
		else if (!since_term[DLY_W])
			since_term <= since_term + 1'b1;
	end

	AST_TX_STOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$fell(st.tx_busy) |-> o_txd && $past(o_txd))
		else $error("stop bit not high");
	AST_TX_START: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_load |=> !o_txd && o_tx_en)
		else $error("start bit missing");
	AST_HALF_DUPLEX: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st.tx_busy |-> !st.rx_busy && !st.rx_vld)
		else $error("receiving while sending");
	AST_CR_LF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_load && tx_ch == CH_CR |=> st.state == S_LF)
		else $error("CR not followed by LF");
	AST_WRITE_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st.reg_req |-> st.state == S_CAPT && !st.tx_busy)
		else $error("access during reply");
	AST_DOL_WIN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_load && st.first && st.dol |->
		since_term >= DOL_LO &&
		since_term <= DOL_HI)
		else $error("dollar reply outside window");
	AST_AST_WIN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_load && st.first && !st.dol |->
		since_term >= AST_LO &&
		since_term <= AST_HI)
		else $error("asterisk reply outside window");
	AST_BACK_IDLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st.state == S_DONE && !st.tx_busy |=> st.state == S_IDLE)
		else $error("no return to idle");
	AST_BAD_OP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st.state == S_NODE && st.rx_vld && (st.rx_byte & CASE_MASK) != CH_R
		&& (st.rx_byte & CASE_MASK) != CH_W
		&& !(st.rx_byte >= CH_ZERO && st.rx_byte <= CH_NINE)
		|=> st.state == S_IDLE)
		else $error("bad operation not abandoned");
	AST_FOREIGN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st.state <= S_DATA && n.state == S_WAIT |->
		st.node == '0 || st.node == i_node_addr)
		else $error("reply to foreign node");

endmodule : asp_parser

/* File: src/asp_pkg.sv */
// Constants, types and helpers of the ASCII serial command parser.
// Assumes a single 100 MHz clock and a serial line sampled on it.
package asp_pkg;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int BAUD_DEF = 9600;
	localparam int BAUD_DIV_DEF = CLK_HZ / BAUD_DEF;
	localparam int DOL_MIN_MS = 50;
	localparam int DOL_MAX_MS = 100;
	localparam int AST_MIN_MS = 2;
	localparam int AST_MAX_MS = 50;
	localparam int DOL_MIN_CYC = DOL_MIN_MS * CLK_KHZ;
	localparam int DOL_MAX_CYC = DOL_MAX_MS * CLK_KHZ;
	localparam int AST_MIN_CYC = AST_MIN_MS * CLK_KHZ;
	localparam int AST_MAX_CYC = AST_MAX_MS * CLK_KHZ;
	localparam int DIV_W = 16;
	localparam int DLY_W = 24;
	localparam int FRAME_BITS = 10;

	// ***************************************************************
	// Characters, modes and limits
	// ***************************************************************
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_DOL = 8'h24;
	localparam logic [7:0] CH_AST = 8'h2A;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_Z = 8'h5A;
	localparam logic [7:0] CASE_MASK = 8'hDF;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [11:0] NODE_MAX = 12'h0FF;
	localparam logic [19:0] ADDR_MAX = 20'h0FFFF;
	localparam logic [3:0] DATA_DIGITS = 4'h7;
	localparam logic [3:0] TOP_DIGIT = 4'h9;

	typedef enum logic [3:0] {
		S_IDLE, S_NODE, S_ADDR, S_DATA, S_WAIT, S_ACC, S_CAPT,
		S_SIGN, S_DIV, S_DIG, S_NUL, S_CR, S_LF, S_DONE
	} asp_st_e;

	typedef struct packed {
		asp_st_e state;
		logic rx_busy;
		logic [DIV_W-1:0] rx_cnt;
		logic [3:0] rx_n;
		logic [9:0] rx_sh;
		logic rx_vld;
		logic [7:0] rx_byte;
		logic rx_err;
		logic tx_busy;
		logic [DIV_W-1:0] tx_cnt;
		logic [3:0] tx_n;
		logic [9:0] tx_sh;
		logic txd;
		logic [7:0] node;
		logic wr;
		logic has_addr;
		logic lt;
		logic addr_bad;
		logic [15:0] addr;
		logic neg;
		logic [3:0] ndig;
		logic [31:0] data;
		logic dol;
		logic [DLY_W-1:0] dly;
		logic reg_req;
		logic [31:0] mag;
		logic [3:0] pidx;
		logic [3:0] dig;
		logic started;
		logic first;
	} asp_s;

	function automatic logic [31:0] pow10(input logic [3:0] i);
		case (i)
			4'h0: pow10 = 32'h0000_0001;
			4'h1: pow10 = 32'h0000_000A;
			4'h2: pow10 = 32'h0000_0064;
			4'h3: pow10 = 32'h0000_03E8;
			4'h4: pow10 = 32'h0000_2710;
			4'h5: pow10 = 32'h0001_86A0;
			4'h6: pow10 = 32'h000F_4240;
			4'h7: pow10 = 32'h0098_9680;
			4'h8: pow10 = 32'h05F5_E100;
			default: pow10 = 32'h3B9A_CA00;
		endcase
	endfunction : pow10

endpackage : asp_pkg

/* File: verification/asp_host.sv */
// Host model: sends command strings and collects the serial reply.
// Assumes the line idles high and the same parity setting at both ends.
`timescale 1ns/1ps
module asp_host
	import asp_pkg::*;
#(
	parameter int BAUD_DIV = 8
)(
	input wire logic i_clk,
	input wire logic [1:0] i_parity,
	input wire logic i_txd,
	input wire logic i_tx_en,
	output logic o_rxd
);
	int cyc = 0;
	int t_term;
	int t_first;
	logic frm_bad = 1'b0;

	initial o_rxd = 1'b1;

	always @(posedge i_clk) cyc <= cyc + 1;

	// ********************
	// Transmit
	// ********************
	// err[0] breaks the stop bit, err[1] the parity, of the last character
	task automatic send_str(input string s, input logic [1:0] err);
		logic [7:0] b;
		logic lst;
		logic p;
		logic st;
		logic [10:0] fr;
		int n;
		@(posedge i_clk);
		for (int k = 0; k < s.len(); k++)
		begin
			b = s[k];
			lst = (k == s.len() - 1);
			p = ^b ^ (i_parity == PAR_ODD) ^ (lst & err[1]);
			st = ~(lst & err[0]);
			n = (i_parity == PAR_NONE) ? 10 : 11;
			fr = (i_parity == PAR_NONE) ? {1'b1, st, b, 1'b0}
				: {st, p, b, 1'b0};
			for (int i = 0; i < n; i++)
			begin
				o_rxd <= fr[i];
				repeat (BAUD_DIV) @(posedge i_clk);
			end
		end
		o_rxd <= 1'b1;
		t_term = cyc;
	endtask : send_str

	// ********************
	// Receive
	// ********************
	// A NUL byte is kept as a tilde, since strings drop zero bytes
	task automatic recv(input int maxw, output string s);
		logic [7:0] b;
		int w;
		s = "";
		w = maxw;
		forever
		begin
			while (i_txd !== 1'b0 && w > 0)
			begin
				@(posedge i_clk);
				w--;
			end
			if (w == 0)
				return;
			if (s.len() == 0)
				t_first = cyc;
			repeat (BAUD_DIV / 2) @(posedge i_clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BAUD_DIV) @(posedge i_clk);
				b[i] = i_txd;
				if (i_tx_en !== 1'b1)
					frm_bad = 1'b1;
			end
			if (i_parity != PAR_NONE)
			begin
				repeat (BAUD_DIV) @(posedge i_clk);
				if (i_txd !== (^b ^ (i_parity == PAR_ODD)))
					frm_bad = 1'b1;
			end
			repeat (BAUD_DIV) @(posedge i_clk);
			if (i_txd !== 1'b1)
				frm_bad = 1'b1;
			s = {s, (b == 8'h00) ? "~" : string'(b)};
			w = 4 * BAUD_DIV;
		end
	endtask : recv
endmodule : asp_host

/* File: verification/asp_parser_bench.sv */
// Self-checking bench of the serial command parser with a host model.
// Assumes shortened baud divider and reply delays for a brief run.
`timescale 1ns/1ps
module asp_parser_bench
	import asp_pkg::*;
;
	localparam int BD = 8;
	localparam int DOL_C = 200;
	localparam int AST_C = 50;
	logic clk;
	logic sys_rst;
	logic rxd;
	logic [1:0] parity;
	logic [7:0] node_addr;
	logic [31:0] reg_rdata;
	logic reg_ok;
	logic txd;
	logic tx_en;
	logic reg_req;
	logic reg_we;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata;
	int n_fail = 0;
	int n_tests = 0;
	int n_req = 0;
	int t_req = 0;

	asp_parser #(.BAUD_DIV(BD), .DOL_CYC(DOL_C), .AST_CYC(AST_C)) u_dut (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_rxd(rxd), .i_parity(parity),
		.i_node_addr(node_addr), .i_reg_rdata(reg_rdata),
		.i_reg_ok(reg_ok), .o_txd(txd), .o_tx_en(tx_en),
		.o_reg_req(reg_req), .o_reg_we(reg_we), .o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata));

	asp_host #(.BAUD_DIV(BD)) u_host (.i_clk(clk), .i_parity(parity),
		.i_txd(txd), .i_tx_en(tx_en), .o_rxd(rxd));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (reg_req === 1'b1)
		begin
			n_req <= n_req + 1;
			t_req <= u_host.cyc;
		end

	// ********************
	// Helpers
	// ********************
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic chks(input string what, input string exp, input string got);
		n_tests++;
		if (got != exp)
		begin
			n_fail++;
			$display("ERROR %s expected '%s' seen '%s'", what, exp, got);
		end
	endtask : chks

	function automatic logic win(input int c);
		int d;
		d = u_host.t_first - u_host.t_term;
		return d >= c - BD && d <= c + 120;
	endfunction : win

	// nreq below zero leaves the request count unchecked
	task automatic cmd(input string s, input logic [1:0] err, input int nreq,
		output string r);
		int n0;
		n0 = n_req;
		u_host.send_str(s, err);
		u_host.recv((nreq != 0) ? DOL_C + 400 : 400, r);
		if (nreq >= 0)
			chk("req_cnt", n0 + nreq, n_req);
	endtask : cmd

	task automatic end_sim();
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// ********************
	// Scenarios
	// ********************
	task automatic t_half();
		string r;
		int n0;
		reg_rdata <= 32'h0000_04D2;
		n0 = n_req;
		u_host.send_str("SR*", 2'b00);
		fork
			u_host.recv(AST_C + 400, r);
			begin
				repeat (AST_C + 40) @(posedge clk);
				u_host.send_str("SR*", 2'b00);
			end
		join
		chks("half_rep", "1234\r\n", r);
		chk("half_req", n0 + 1, n_req);
		cmd("", 2'b00, 0, r);
		chks("half_quiet", "", r);
		cmd("SR$", 2'b00, 1, r);
		chks("rd_disp", "1234\r\n", r);
		chk("rd_disp_reg", 17'h0_0000, {reg_we, reg_addr});
		chk("dol_win", 1'b1, win(DOL_C));
	endtask : t_half

	task automatic t_addr();
		string r;
		string s[4] = '{"xQs5rl*", "SRa*", "SRR*", "SR65535*"};
		logic [15:0] a[4] = '{16'h000C, 16'h0001, 16'h0012, 16'hFFFF};
		reg_rdata <= 32'hFFFF_FFC8;
		foreach (s[i])
		begin
			cmd(s[i], 2'b00, 1, r);
			chks("rd_neg", "-56\r\n", r);
			chk("rd_addr", {1'b0, a[i]}, {reg_we, reg_addr});
			chk("ast_win", 1'b1, win(AST_C));
		end
	endtask : t_addr

	task automatic t_write();
		string r;
		string s[2] = '{"S5W148,-9999999*", "s0w3 7$"};
		logic [31:0] d[2] = '{32'hFF67_6981, 32'h0000_0007};
		logic [15:0] a[2] = '{16'h0094, 16'h0003};
		foreach (s[i])
		begin
			cmd(s[i], 2'b00, 1, r);
			chks("wr_reply", "\r\n", r);
			chk("wr_reg", {1'b1, a[i], d[i]}, {reg_we, reg_addr, reg_wdata});
			chk("wr_first", 1'b1, t_req < u_host.t_first);
		end
	endtask : t_write

	task automatic t_invalid();
		string r;
		string s[3] = '{"SR5*", "SRT*", "SR70000*"};
		foreach (s[i])
		begin
			reg_ok <= (i != 0);
			cmd(s[i], 2'b00, -1, r);
			chks("invalid", "~\r\n", r);
		end
	endtask : t_invalid

	task automatic t_silent();
		string r;
		string s[5] = '{"S7R*", "S5X*", "S256R*", "SW1,12345678*", "SR*"};
		foreach (s[i])
		begin
			cmd(s[i], (i == 4) ? 2'b01 : 2'b00, 0, r);
			chks("silent", "", r);
		end
	endtask : t_silent

	task automatic t_parity();
		string r;
		logic [1:0] m[2] = '{PAR_ODD, PAR_EVEN};
		reg_rdata <= 32'h0000_0007;
		foreach (m[i])
		begin
			parity <= m[i];
			cmd("SR*", 2'b00, 1, r);
			chks("par_rep", "7\r\n", r);
			cmd("SR*", 2'b10, 0, r);
			chks("par_bad", "", r);
		end
		parity <= PAR_NONE;
	endtask : t_parity

	// ********************
	// Main sequence
	// ********************
	initial
	begin
		sys_rst = 1'b1;
		parity = PAR_NONE;
		node_addr = 8'h05;
		reg_rdata = 32'h0000_0000;
		reg_ok = 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		chk("reset_line", 3'h2, {tx_en, txd, reg_req});
		t_half();
		t_addr();
		t_write();
		t_invalid();
		t_silent();
		t_parity();
		chk("frame_ok", 1'b0, u_host.frm_bad);
		end_sim();
	end

	// Bound far above about twenty commands of at most some fifteen hundred cycles each
	initial
	begin
		repeat (90000) @(posedge clk);
		n_fail++;
		end_sim();
	end
endmodule : asp_parser_bench
